// *** hw/tpcoc_core.sv ***
// Configuration and output control of a three-loop clock generator: loop
// dividers, crosspoint, post dividers, general-purpose pin and oscillator trims.
// Assumes a 100 MHz system clock fast against the reference and loop rates;
// loops are modelled as edge-rate generators in that clock domain.
//
// Contract
// - Each loop runs at reference over eight-bit pre-divider times eleven-bit feedback.
// - Four sources, reference or any loop, route to any of three outputs.
// - Each output passes its source through its own seven-bit post divider.
// - General-purpose pin serves one of four functions.
// - Frequency select picks loop one setting and output A/B divisors.
// - Divider changes from frequency select are glitch free.
// - Outputs A and B each take divisor from one of two registers.
// - Output C always takes divisor from one register.
// - Pin may drive suspend together with another function.
// - Output-enable use: low level tri-states all three outputs.
// - Shutdown use: low tri-states outputs, stops loops, counters, oscillator.
// - Leaving shutdown, loops relock before their clocks are valid.
// - Suspend use: low disables a programmed subset of loops and outputs.
// - Suspend stops logic of suspended loops and tri-states suspended outputs.
// - Six-bit load capacitance code, 0.375 pF steps, 6 to 30 pF.
// - A setting fully bypasses input load capacitors for driven clocks.
// - Oscillator drive strength comes from a programmed setting.
// - Inverted loop phase may be selected for an output to stagger edges.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
module tpcoc_core
#(
   parameter int LOCK_CYCLES = tpcoc_pkg::TPCOC_LOCK_CYCLES,
   parameter int DRIVE_W = 2
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out,
   input wire logic crystal_in,
   input wire logic frequency_select_in,
   output logic clock_out_a,
   output logic clock_out_a_oe_out,
   output logic clock_out_b,
   output logic clock_out_b_oe_out,
   output logic clock_out_c,
   output logic clock_out_c_oe_out,
   output logic oscillator_enable_out,
   output logic [5:0] load_cap_code_out,
   output logic load_cap_bypass_out,
   output logic [DRIVE_W-1:0] drive_strength_out
);

   localparam int LCW = $clog2(LOCK_CYCLES + 1);
   localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_CYCLES);

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic loaded_q;
   logic [1:0] func_q;
   logic susp_also_q;
   logic bypass_q;
   logic [DRIVE_W-1:0] drive_q;
   logic [5:0] cap_q;
   logic [2:0] susp_loop_q;
   logic [2:0] susp_out_q;
   logic [7:0] q_set_q [4];
   logic [10:0] p_set_q [4];
   logic [1:0] src_q [3];
   logic inv_q [3];
   logic [6:0] div_set_q [5];

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         loaded_q <= 1'b0;
         func_q <= tpcoc_pkg::TPCOC_FN_FREQ_SELECT;
         susp_also_q <= 1'b0;
         bypass_q <= 1'b0;
         drive_q <= DRIVE_W'(tpcoc_pkg::TPCOC_RST_DRIVE);
         cap_q <= tpcoc_pkg::TPCOC_RST_CAP;
         susp_loop_q <= 3'h0;
         susp_out_q <= 3'h0;
         for (int i = 0; i < 4; i++)
         begin
            q_set_q[i] <= tpcoc_pkg::TPCOC_RST_Q;
            p_set_q[i] <= tpcoc_pkg::TPCOC_RST_P;
         end
         for (int i = 0; i < 3; i++)
         begin
            src_q[i] <= tpcoc_pkg::TPCOC_SRC_REF;
            inv_q[i] <= 1'b0;
         end
         for (int i = 0; i < 5; i++)
         begin
            div_set_q[i] <= tpcoc_pkg::TPCOC_RST_DIV;
         end
      end
      else if (reg_write_in)
      begin
         case (reg_addr_in)
            tpcoc_pkg::TPCOC_ADDR_CTRL:
            begin
               loaded_q <= reg_wdata_in[tpcoc_pkg::TPCOC_CTRL_LOADED];
               func_q <= reg_wdata_in[tpcoc_pkg::TPCOC_CTRL_FUNC_LO +: 2];
               susp_also_q <= reg_wdata_in[tpcoc_pkg::TPCOC_CTRL_SUSP_ALSO];
               bypass_q <= reg_wdata_in[tpcoc_pkg::TPCOC_CTRL_BYPASS];
               drive_q <= reg_wdata_in[tpcoc_pkg::TPCOC_CTRL_DRIVE_LO +: DRIVE_W];
               cap_q <= reg_wdata_in[tpcoc_pkg::TPCOC_CTRL_CAP_LO +: 6];
            end
            tpcoc_pkg::TPCOC_ADDR_SUSPEND:
            begin
               susp_loop_q <= reg_wdata_in[tpcoc_pkg::TPCOC_SUSP_LOOP_LO +: 3];
               susp_out_q <= reg_wdata_in[tpcoc_pkg::TPCOC_SUSP_OUT_LO +: 3];
            end
            tpcoc_pkg::TPCOC_ADDR_LOOP1_SET0,
            tpcoc_pkg::TPCOC_ADDR_LOOP1_SET1,
            tpcoc_pkg::TPCOC_ADDR_LOOP2,
            tpcoc_pkg::TPCOC_ADDR_LOOP3:
            begin
               q_set_q[reg_addr_in[3:2] - 2'h2] <= reg_wdata_in[tpcoc_pkg::TPCOC_LOOP_Q_LO +: 8];
               p_set_q[reg_addr_in[3:2] - 2'h2] <= reg_wdata_in[tpcoc_pkg::TPCOC_LOOP_P_LO +: 11];
            end
            tpcoc_pkg::TPCOC_ADDR_ROUTE:
            begin
               for (int i = 0; i < 3; i++)
               begin
                  src_q[i] <= reg_wdata_in[i*tpcoc_pkg::TPCOC_ROUTE_STRIDE +: 2];
                  inv_q[i] <= reg_wdata_in[i*tpcoc_pkg::TPCOC_ROUTE_STRIDE
                                           + tpcoc_pkg::TPCOC_ROUTE_INV];
               end
            end
            tpcoc_pkg::TPCOC_ADDR_DIV_A:
            begin
               div_set_q[0] <= reg_wdata_in[6:0];
               div_set_q[1] <= reg_wdata_in[tpcoc_pkg::TPCOC_DIV_SET1_LO +: 7];
            end
            tpcoc_pkg::TPCOC_ADDR_DIV_B:
            begin
               div_set_q[2] <= reg_wdata_in[6:0];
               div_set_q[3] <= reg_wdata_in[tpcoc_pkg::TPCOC_DIV_SET1_LO +: 7];
            end
            tpcoc_pkg::TPCOC_ADDR_DIV_C:
            begin
               div_set_q[4] <= reg_wdata_in[6:0];
            end
            default:
            begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin inputs: two-flop synchronisers
   // ------------------------------------------------------------
   logic [1:0] xtal_sync_q;
   logic xtal_last_q;
   logic [1:0] pin_sync_q;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         xtal_sync_q <= 2'h0;
         xtal_last_q <= 1'b0;
         pin_sync_q <= 2'h3;
      end
      else
      begin
         xtal_sync_q <= {xtal_sync_q[0], crystal_in};
         xtal_last_q <= xtal_sync_q[1];
         pin_sync_q <= {pin_sync_q[0], frequency_select_in};
      end
   end

   // ------------------------------------------------------------
   // Pin function decode
   // ------------------------------------------------------------
   logic pin_high;
   logic set_sel;
   logic shutdown;
   logic outputs_off;
   logic suspend;
   logic ref_tick;

   assign pin_high = pin_sync_q[1];
   // Frequency select follows the pin only in that use; set 0 otherwise
   assign set_sel = (func_q == tpcoc_pkg::TPCOC_FN_FREQ_SELECT) & pin_high;
   assign shutdown = (func_q == tpcoc_pkg::TPCOC_FN_SHUTDOWN) & ~pin_high;
   assign outputs_off = (func_q == tpcoc_pkg::TPCOC_FN_OUTPUT_ENABLE) & ~pin_high;
   assign suspend = ((func_q == tpcoc_pkg::TPCOC_FN_SUSPEND) | susp_also_q) & ~pin_high;
   // Oscillator is stopped in shutdown, so no reference edges reach the loops
   assign ref_tick = (xtal_sync_q[1] ^ xtal_last_q) & ~shutdown;

   // ------------------------------------------------------------
   // Loops: edge-rate generators with lock timers
   // ------------------------------------------------------------
   logic [3:0] src_tick;
   logic [2:0] loop_locked;

   assign src_tick[0] = ref_tick;

   for (genvar g = 0; g < 3; g++)
   begin : g_loop
      logic [12:0] credit_q;
      logic [LCW-1:0] lock_q;
      logic [7:0] q_div;
      logic [10:0] p_mul;
      logic [12:0] q_ext;
      logic stop;
      logic emit;

      if (g == 0)
      begin : g_sel
         assign q_div = set_sel ? q_set_q[1] : q_set_q[0];
         assign p_mul = set_sel ? p_set_q[1] : p_set_q[0];
      end
      else
      begin : g_fix
         assign q_div = q_set_q[g+1];
         assign p_mul = p_set_q[g+1];
      end

      // A zero pre-divider is treated as one
      assign q_ext = (q_div == 8'h00) ? 13'h0001 : {5'h00, q_div};
      assign stop = shutdown | (suspend & susp_loop_q[g]);
      assign emit = (credit_q >= q_ext) & (lock_q == LOCK_LAST);

      // Output edge rate is reference edge rate times P over Q, at most one per clock
      always_ff @(posedge clock_in)
      begin
         if (rst_in | stop)
         begin
            credit_q <= 13'h0000;
         end
         else
         begin
            credit_q <= credit_q + (ref_tick ? {2'h0, p_mul} : 13'h0000)
                        - (emit ? q_ext : 13'h0000);
         end
      end

      // Every restart counts the full lock time before edges are passed on
      always_ff @(posedge clock_in)
      begin
         if (rst_in | stop)
         begin
            lock_q <= '0;
         end
         else if (lock_q != LOCK_LAST)
         begin
            lock_q <= lock_q + LCW'(1);
         end
      end

      assign src_tick[g+1] = emit;
      assign loop_locked[g] = (lock_q == LOCK_LAST);
   end

   // ------------------------------------------------------------
   // Crosspoint and post dividers
   // ------------------------------------------------------------
   logic [2:0] clk_q;
   logic [2:0] oe_q;

   for (genvar g = 0; g < 3; g++)
   begin : g_out
      logic [6:0] cnt_q;
      logic [6:0] div_q;
      logic phase_q;
      logic [6:0] div_next;
      logic [6:0] div_eff;
      logic tick;
      logic enable;

      if (g < 2)
      begin : g_two
         assign div_next = set_sel ? div_set_q[2*g+1] : div_set_q[2*g];
      end
      else
      begin : g_one
         assign div_next = div_set_q[4];
      end

      assign div_eff = (div_q == 7'h00) ? 7'h01 : div_q;
      assign tick = src_tick[src_q[g]];
      assign enable = loaded_q & ~shutdown & ~outputs_off
                      & ~(suspend & susp_out_q[g]);

      // Counters halt in shutdown or while their output is suspended, and restart from a low phase
      always_ff @(posedge clock_in)
      begin
         if (rst_in | shutdown | (suspend & susp_out_q[g]))
         begin
            cnt_q <= 7'h00;
            phase_q <= 1'b0;
            div_q <= div_next;
         end
         else if (tick)
         begin
            if (cnt_q >= div_eff - 7'h01)
            begin
               cnt_q <= 7'h00;
               phase_q <= ~phase_q;
               // New divisor only at the end of a full period, so no runt pulse
               if (phase_q)
               begin
                  div_q <= div_next;
               end
            end
            else
            begin
               cnt_q <= cnt_q + 7'h01;
            end
         end
      end

      always_ff @(posedge clock_in)
      begin
         if (rst_in)
         begin
            clk_q[g] <= 1'b0;
            oe_q[g] <= 1'b0;
         end
         else
         begin
            clk_q[g] <= phase_q ^ inv_q[g];
            oe_q[g] <= enable;
         end
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (reg_addr_in)
         tpcoc_pkg::TPCOC_ADDR_CTRL:
         begin
            rdata_d[tpcoc_pkg::TPCOC_CTRL_LOADED] = loaded_q;
            rdata_d[tpcoc_pkg::TPCOC_CTRL_FUNC_LO +: 2] = func_q;
            rdata_d[tpcoc_pkg::TPCOC_CTRL_SUSP_ALSO] = susp_also_q;
            rdata_d[tpcoc_pkg::TPCOC_CTRL_BYPASS] = bypass_q;
            rdata_d[tpcoc_pkg::TPCOC_CTRL_DRIVE_LO +: DRIVE_W] = drive_q;
            rdata_d[tpcoc_pkg::TPCOC_CTRL_CAP_LO +: 6] = cap_q;
         end
         tpcoc_pkg::TPCOC_ADDR_SUSPEND:
         begin
            rdata_d[tpcoc_pkg::TPCOC_SUSP_LOOP_LO +: 3] = susp_loop_q;
            rdata_d[tpcoc_pkg::TPCOC_SUSP_OUT_LO +: 3] = susp_out_q;
         end
         tpcoc_pkg::TPCOC_ADDR_LOOP1_SET0,
         tpcoc_pkg::TPCOC_ADDR_LOOP1_SET1,
         tpcoc_pkg::TPCOC_ADDR_LOOP2,
         tpcoc_pkg::TPCOC_ADDR_LOOP3:
         begin
            rdata_d[tpcoc_pkg::TPCOC_LOOP_Q_LO +: 8] = q_set_q[reg_addr_in[3:2] - 2'h2];
            rdata_d[tpcoc_pkg::TPCOC_LOOP_P_LO +: 11] = p_set_q[reg_addr_in[3:2] - 2'h2];
         end
         tpcoc_pkg::TPCOC_ADDR_ROUTE:
         begin
            for (int i = 0; i < 3; i++)
            begin
               rdata_d[i*tpcoc_pkg::TPCOC_ROUTE_STRIDE +: 2] = src_q[i];
               rdata_d[i*tpcoc_pkg::TPCOC_ROUTE_STRIDE + tpcoc_pkg::TPCOC_ROUTE_INV] = inv_q[i];
            end
         end
         tpcoc_pkg::TPCOC_ADDR_DIV_A:
         begin
            rdata_d[6:0] = div_set_q[0];
            rdata_d[tpcoc_pkg::TPCOC_DIV_SET1_LO +: 7] = div_set_q[1];
         end
         tpcoc_pkg::TPCOC_ADDR_DIV_B:
         begin
            rdata_d[6:0] = div_set_q[2];
            rdata_d[tpcoc_pkg::TPCOC_DIV_SET1_LO +: 7] = div_set_q[3];
         end
         tpcoc_pkg::TPCOC_ADDR_DIV_C:
         begin
            rdata_d[6:0] = div_set_q[4];
         end
         tpcoc_pkg::TPCOC_ADDR_STATUS:
         begin
            rdata_d[tpcoc_pkg::TPCOC_STAT_LOCK_LO +: 3] = loop_locked;
            rdata_d[tpcoc_pkg::TPCOC_STAT_PIN] = pin_high;
            rdata_d[tpcoc_pkg::TPCOC_STAT_OE_LO +: 3] = oe_q;
            rdata_d[tpcoc_pkg::TPCOC_STAT_SHUT] = shutdown;
         end
         default:
         begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         rdata_q <= reg_read_in ? rdata_d : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata_out = rdata_q;
   assign clock_out_a = clk_q[0];
   assign clock_out_b = clk_q[1];
   assign clock_out_c = clk_q[2];
   assign clock_out_a_oe_out = oe_q[0];
   assign clock_out_b_oe_out = oe_q[1];
   assign clock_out_c_oe_out = oe_q[2];
   assign oscillator_enable_out = ~shutdown;
   assign load_cap_code_out = cap_q;
   assign load_cap_bypass_out = bypass_q;
   assign drive_strength_out = drive_q;

endmodule

// *** hw/tpcoc_pkg.sv ***
// Constants of the three-loop clock generator: register map, field layout,
// reset values and timing figures.
// Assumes a single 100 MHz system clock and a plain register port.
package tpcoc_pkg;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] TPCOC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] TPCOC_ADDR_SUSPEND = 8'h04;
   localparam logic [7:0] TPCOC_ADDR_LOOP1_SET0 = 8'h08;
   localparam logic [7:0] TPCOC_ADDR_LOOP1_SET1 = 8'h0C;
   localparam logic [7:0] TPCOC_ADDR_LOOP2 = 8'h10;
   localparam logic [7:0] TPCOC_ADDR_LOOP3 = 8'h14;
   localparam logic [7:0] TPCOC_ADDR_ROUTE = 8'h18;
   localparam logic [7:0] TPCOC_ADDR_DIV_A = 8'h1C;
   localparam logic [7:0] TPCOC_ADDR_DIV_B = 8'h20;
   localparam logic [7:0] TPCOC_ADDR_DIV_C = 8'h24;
   localparam logic [7:0] TPCOC_ADDR_STATUS = 8'h28;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int TPCOC_CTRL_LOADED = 0;
   localparam int TPCOC_CTRL_FUNC_LO = 1;
   localparam int TPCOC_CTRL_SUSP_ALSO = 3;
   localparam int TPCOC_CTRL_BYPASS = 4;
   localparam int TPCOC_CTRL_DRIVE_LO = 5;
   localparam int TPCOC_CTRL_CAP_LO = 8;
   localparam int TPCOC_SUSP_LOOP_LO = 0;
   localparam int TPCOC_SUSP_OUT_LO = 4;
   localparam int TPCOC_LOOP_Q_LO = 0;
   localparam int TPCOC_LOOP_P_LO = 16;
   localparam int TPCOC_ROUTE_STRIDE = 4;
   localparam int TPCOC_ROUTE_INV = 2;
   localparam int TPCOC_DIV_SET1_LO = 8;
   localparam int TPCOC_STAT_LOCK_LO = 0;
   localparam int TPCOC_STAT_PIN = 3;
   localparam int TPCOC_STAT_OE_LO = 4;
   localparam int TPCOC_STAT_SHUT = 7;

   // ------------------------------------------------------------
   // Pin functions and crosspoint sources
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TPCOC_FN_FREQ_SELECT = 2'h0,
      TPCOC_FN_SUSPEND = 2'h1,
      TPCOC_FN_OUTPUT_ENABLE = 2'h2,
      TPCOC_FN_SHUTDOWN = 2'h3
   } tpcoc_func_t;

   localparam logic [1:0] TPCOC_SRC_REF = 2'h0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] TPCOC_RST_Q = 8'h01;
   localparam logic [10:0] TPCOC_RST_P = 11'h001;
   localparam logic [6:0] TPCOC_RST_DIV = 7'h01;
   localparam logic [5:0] TPCOC_RST_CAP = 6'h00;
   localparam logic [1:0] TPCOC_RST_DRIVE = 2'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int TPCOC_CLK_MHZ = 100;
   localparam int TPCOC_LOCK_TIME_US = 100;
   localparam int TPCOC_LOCK_CYCLES = TPCOC_LOCK_TIME_US * TPCOC_CLK_MHZ;

endpackage

// *** sim/tpcoc_core_chk.sv ***
// Port checks of the clock generator, with a shadow of the control word.
// Assumes the plain register port and the package's pin function codes.
`timescale 1ns/100ps
module tpcoc_core_chk
#(
   parameter int LOCK_CYCLES = 8,
   parameter int DRIVE_W = 2
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic frequency_select_in,
   input wire logic clock_out_a_oe_out,
   input wire logic clock_out_b_oe_out,
   input wire logic clock_out_c_oe_out,
   input wire logic oscillator_enable_out,
   input wire logic [5:0] load_cap_code_out,
   input wire logic load_cap_bypass_out,
   input wire logic [DRIVE_W-1:0] drive_strength_out
);
   logic [13:0] ctrl_q;
   logic [2:0] oe;
   logic [1:0] fn;
   assign oe = {clock_out_c_oe_out, clock_out_b_oe_out, clock_out_a_oe_out};
   assign fn = ctrl_q[2:1];
   default clocking dc @(posedge clock_in); endclocking
   default disable iff (rst_in);

   // ------------------------------------------------------------
   // Shadow of the control word
   // ------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         ctrl_q <= 14'h0000;
      else if (reg_write_in && reg_addr_in == tpcoc_pkg::TPCOC_ADDR_CTRL)
         ctrl_q <= reg_wdata_in[13:0];
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_read_idle_zero: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
      else $error("read data present outside its slot");
   a_ctrl_read_back: assert property (
      reg_read_in && reg_addr_in == 8'h00 |=> reg_rdata_out == {18'h0, ctrl_q & 14'h3F7F})
      else $error("control word read back wrong");
   a_oe_low_tristate: assert property (
      (fn == 2'h2 && !frequency_select_in)[*6] |-> oe == 3'h0)
      else $error("outputs driven while enable pin low");
   a_oe_high_drives: assert property (
      (ctrl_q[0] && fn == 2'h2 && frequency_select_in)[*6] |-> oe == 3'h7)
      else $error("outputs idle while enable pin high");
   a_shut_all_stop: assert property (
      (fn == 2'h3 && !frequency_select_in)[*6] |-> oe == 3'h0 && !oscillator_enable_out)
      else $error("shutdown left outputs or oscillator on");
   a_osc_kept_on: assert property (fn != 2'h3 |-> oscillator_enable_out)
      else $error("oscillator stopped outside shutdown");
   a_no_load_idle: assert property (!ctrl_q[0] |=> oe == 3'h0)
      else $error("output enabled before settings loaded");
   a_cap_code: assert property (load_cap_code_out == ctrl_q[13:8])
      else $error("load cap code differs from setting");
   a_osc_trims: assert property (
      load_cap_bypass_out == ctrl_q[4] && drive_strength_out == DRIVE_W'(ctrl_q[6:5]))
      else $error("bypass or drive differs from setting");
endmodule

bind tpcoc_core tpcoc_core_chk #(.LOCK_CYCLES(LOCK_CYCLES), .DRIVE_W(DRIVE_W)) u_chk (
   .clock_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
   .reg_rdata_out, .frequency_select_in, .clock_out_a_oe_out, .clock_out_b_oe_out,
   .clock_out_c_oe_out, .oscillator_enable_out, .load_cap_code_out, .load_cap_bypass_out,
   .drive_strength_out);

// *** sim/tpcoc_ref_src.sv ***
// Reference source and board loads seen by the clock generator.
// Assumes a 10 ns bench clock; the reference runs free, like a crystal.
`timescale 1ns/100ps
module tpcoc_ref_src
#(
   parameter int HALF_NS = 40
)
(
   input wire logic [2:0] clk_in,
   input wire logic [2:0] oe_in,
   output logic crystal_out,
   output logic [2:0] pad_out
);
   logic float_q;
   // ------------------------------------------------------------
   // Reference and pad levels
   // ------------------------------------------------------------
   // Offset edges keep the reference away from the bench clock edges
   initial
   begin
      crystal_out = 1'b0;
      float_q = 1'b0;
      #2;
      fork
         forever #(HALF_NS) crystal_out = ~crystal_out;
         forever #10 float_q = ~float_q;
      join
   end
   // An undriven pad wanders instead of holding its last level
   assign pad_out = (oe_in & clk_in) | (~oe_in & {3{float_q}});
endmodule

// *** sim/tpcoc_core_tb.sv ***
// Self-checking bench of the clock generator: registers, dividers, pin.
// Assumes the partner drives a reference edge every 4 clock cycles.
`timescale 1ns/100ps
module tpcoc_core_tb;
   logic clock_in, rst_in, reg_write_in, reg_read_in, frequency_select_in;
   logic [7:0] reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, v;
   logic crystal_in, osc_en, bypass;
   logic [2:0] clk, oe, pad;
   logic [5:0] cap;
   logic [1:0] drive;
   int error_cnt = 0;
   int comparisons = 0;

   tpcoc_core #(.LOCK_CYCLES(8)) u_dut (
      .clock_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
      .reg_rdata_out, .crystal_in, .frequency_select_in, .clock_out_a(clk[0]),
      .clock_out_a_oe_out(oe[0]), .clock_out_b(clk[1]), .clock_out_b_oe_out(oe[1]),
      .clock_out_c(clk[2]), .clock_out_c_oe_out(oe[2]), .oscillator_enable_out(osc_en),
      .load_cap_code_out(cap), .load_cap_bypass_out(bypass), .drive_strength_out(drive));
   tpcoc_ref_src u_src (.clk_in(clk), .oe_in(oe), .crystal_out(crystal_in), .pad_out(pad));

   // ------------------------------------------------------------
   // Bus, pin and measuring tasks
   // ------------------------------------------------------------
   task automatic check(input bit ok, input string msg);
      comparisons++;
      if (!ok)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      @(negedge clock_in);
      v = reg_rdata_out;
   endtask
   task automatic pin(input logic lvl);
      @(posedge clock_in);
      frequency_select_in <= lvl;
      repeat (8) @(negedge clock_in);
   endtask
   task automatic rise(input int i);
      logic last;
      last = pad[i];
      for (int k = 0; k < 4000; k++)
      begin
         @(negedge clock_in);
         if (pad[i] === 1'b1 && last === 1'b0)
            return;
         last = pad[i];
      end
      check(1'b0, "no output edge");
   endtask
   // Four periods are timed so a one-cycle phase wobble stays within slack
   task automatic period(input int i, input int cyc);
      time t0;
      int dt;
      rise(i);
      t0 = $time;
      repeat (4) rise(i);
      dt = int'(($time - t0) / 10);
      check(dt >= 4 * cyc - 2 && dt <= 4 * cyc + 2, "output period");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check(oe === 3'h0 && osc_en === 1'b1 && cap === 6'h00, "reset outputs");
      rd(tpcoc_pkg::TPCOC_ADDR_CTRL);
      check(v === 32'h0, "control reset");
      rd(tpcoc_pkg::TPCOC_ADDR_LOOP1_SET0);
      check(v === 32'h0001_0001, "loop reset");
      rd(tpcoc_pkg::TPCOC_ADDR_DIV_C);
      check(v === 32'h0000_0001, "divisor reset");
      rd(8'h2C);
      check(v === 32'h0, "unmapped read");
   endtask
   task automatic t_trims();
      wr(tpcoc_pkg::TPCOC_ADDR_CTRL, 32'h0000_3F75);
      @(negedge clock_in);
      check(cap === 6'h3F && bypass === 1'b1 && drive === 2'h3, "trims max");
      wr(tpcoc_pkg::TPCOC_ADDR_CTRL, 32'h0000_0A05);
      @(negedge clock_in);
      check(cap === 6'h0A && bypass === 1'b0 && drive === 2'h0, "trims low");
      rd(tpcoc_pkg::TPCOC_ADDR_CTRL);
      check(v === 32'h0000_0A05, "control read");
   endtask
   task automatic t_divide();
      wr(tpcoc_pkg::TPCOC_ADDR_LOOP2, 32'h0002_0001);
      wr(tpcoc_pkg::TPCOC_ADDR_LOOP1_SET1, 32'h0001_0002);
      wr(tpcoc_pkg::TPCOC_ADDR_ROUTE, 32'h0000_0124);
      wr(tpcoc_pkg::TPCOC_ADDR_DIV_A, 32'h0000_0003);
      wr(tpcoc_pkg::TPCOC_ADDR_DIV_B, 32'h0000_0002);
      wr(tpcoc_pkg::TPCOC_ADDR_DIV_C, 32'h0000_0005);
      repeat (60) @(negedge clock_in);
      check(oe === 3'h7, "outputs on");
      period(0, 24);
      period(1, 8);
      period(2, 40);
   endtask
   task automatic t_fsel();
      time t0;
      wr(tpcoc_pkg::TPCOC_ADDR_CTRL, 32'h0000_0001);
      wr(tpcoc_pkg::TPCOC_ADDR_DIV_A, 32'h0000_0402);
      repeat (80) @(negedge clock_in);
      period(0, 32);
      period(2, 80);
      pin(1'b0);
      rise(0);
      t0 = $time;
      rise(0);
      check(($time - t0) / 10 >= 16, "short period at switch");
      period(0, 16);
      period(2, 40);
   endtask
   task automatic t_susp();
      wr(tpcoc_pkg::TPCOC_ADDR_SUSPEND, 32'h0000_0022);
      wr(tpcoc_pkg::TPCOC_ADDR_CTRL, 32'h0000_0009);
      repeat (10) @(negedge clock_in);
      check(oe === 3'h5, "suspend set");
      rd(tpcoc_pkg::TPCOC_ADDR_STATUS);
      check(v === 32'h0000_0055, "suspend status");
      period(0, 16);
      pin(1'b1);
      repeat (30) @(negedge clock_in);
      check(oe === 3'h7, "resume");
   endtask
   task automatic t_oe_shut();
      wr(tpcoc_pkg::TPCOC_ADDR_CTRL, 32'h0000_0005);
      pin(1'b0);
      check(oe === 3'h0, "enable low");
      pin(1'b1);
      check(oe === 3'h7, "enable high");
      wr(tpcoc_pkg::TPCOC_ADDR_CTRL, 32'h0000_0007);
      pin(1'b0);
      check(oe === 3'h0 && osc_en === 1'b0, "shutdown");
      check(clk === 3'h1, "idle phase");
      rd(tpcoc_pkg::TPCOC_ADDR_STATUS);
      check(v === 32'h0000_0080, "shutdown status");
      pin(1'b1);
      rd(tpcoc_pkg::TPCOC_ADDR_STATUS);
      check(v[2:0] === 3'h0, "lock too early");
      repeat (30) @(negedge clock_in);
      rd(tpcoc_pkg::TPCOC_ADDR_STATUS);
      check(v[2:0] === 3'h7 && oe === 3'h7, "relock");
      period(1, 8);
   endtask

   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial
   begin
      #300000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      rst_in = 1'b1;
      reg_write_in = 1'b0;
      reg_read_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 32'h0;
      frequency_select_in = 1'b1;
      repeat (20) @(posedge clock_in);
      rst_in <= 1'b0;
      @(negedge clock_in);
      t_reset();
      t_trims();
      t_divide();
      t_fsel();
      t_susp();
      t_oe_shut();
      summarize();
   end
endmodule
